/* File: i2c_hold_pkg.sv */
package i2c_hold_pkg;

   // ==========================================================
   // Register byte offsets.
   localparam logic [4:0] off_control_one = 5'h00;
   localparam logic [4:0] off_control_three = 5'h04;
   localparam logic [4:0] off_own_address = 5'h08;
   localparam logic [4:0] off_rx_data = 5'h0C;
   localparam logic [4:0] off_tx_data = 5'h10;
   localparam logic [4:0] off_irq_status = 5'h14;
   localparam logic [4:0] off_irq_clear = 5'h18;
   localparam logic [4:0] off_irq_enable = 5'h1C;

   // ==========================================================
   // Field positions of serial_port_control_one.
   localparam int bit_port_enable = 0;
   localparam int bit_slave_mode = 1;
   localparam int bit_clock_release = 4;
   localparam int bit_nack = 5;

   // Field positions of serial_port_control_three.
   localparam int bit_ack_time = 7;
   localparam int bit_address_hold = 1;
   localparam int bit_data_hold = 0;

   // Field positions of the receive data register.
   localparam int bit_rx_was_address = 8;
   localparam int bit_rx_read_dir = 9;

   // ==========================================================
   // Reset values.
   localparam logic clock_release_reset = 1'b1;
   localparam logic [6:0] own_address_reset = 7'h2A;
   localparam logic [7:0] tx_data_reset = 8'hFF;

   // ==========================================================
   // Interrupt events, one sticky status bit each.
   localparam int irq_bits = 4;
   localparam int irq_address_match = 0;
   localparam int irq_data_received = 1;
   localparam int irq_stop = 2;
   localparam int irq_hold = 3;

   // Bits in each byte of a frame.
   localparam logic [3:0] byte_bits = 4'h8;

   // AXI4-Lite response codes.
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

   // ==========================================================
   // Synchronised two-wire bus line with its edges.
   typedef struct packed {
      logic scl;
      logic sda;
   } wire_pair_t;

   typedef struct packed {
      wire_pair_t level;
      wire_pair_t rise;
      wire_pair_t fall;
   } bus_view_t;

   // Protocol phases of the slave receiver.
   typedef enum logic [2:0] {
      st_idle,
      st_shift,
      st_ack,
      st_master_ack,
      st_wait
   } phase_t;

endpackage : i2c_hold_pkg

/* File: pin_sync.sv */
`timescale 1ns/1ps

module pin_sync import i2c_hold_pkg::*; #(
   parameter int WIDTH = 2
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Asynchronous inputs.
   input wire logic [WIDTH-1:0] pins,
   // Synchronised level and one-cycle edge pulses.
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);

   // ==========================================================
   // Per line: two flops of synchroniser, then one history flop for edges.
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_line
         logic meta;
         logic stable;
         logic prev;
         // The first flop is read only by the second; lines idle high.
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               meta <= 1'b1;
               stable <= 1'b1;
               prev <= 1'b1;
            end else begin
               meta <= pins[i];
               stable <= meta;
               prev <= stable;
            end
         end
         assign level[i] = stable;
         assign rise[i] = stable & ~prev;
         assign fall[i] = ~stable & prev;
      end
   endgenerate

endmodule : pin_sync

/* File: i2c_slave_clock_hold.sv */
`timescale 1ns/1ps
// How it works
// - With address hold on, matching address byte clears clock release at 8th fall.
// - After address hold, SCL stays driven low until software sets clock release.
// - With address hold off, matching addresses neither stretch SCL nor clear release.
// - With data hold on, every received data byte clears clock release at 8th fall.
// - After data hold, SCL held low so acknowledge waits for software release.
// - With data hold off, received data bytes neither clear release nor stretch.
// - Hold enables act only while the port is an enabled two-wire slave.

module i2c_slave_clock_hold import i2c_hold_pkg::*; #(
   parameter int ADDR_WIDTH = 8
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data.
   input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Two-wire bus pins, open drain.
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Interrupt.
   output logic irq
);

   // ==========================================================
   // Elaboration check.
   if (ADDR_WIDTH < 5) begin : g_bad_width
      $error("ADDR_WIDTH must be at least 5");
   end

   // ==========================================================
   // Declarations.
   logic port_enable, slave_mode, clock_release_bit, nack, address_hold_enable, data_hold_enable;
   logic acknowledge_time_status, rx_was_address, is_address, read_dir, hold_now, slave_active, byte_done;
   logic address_match, aw_held, w_held, do_write, wr_mapped, rd_mapped;
   logic [6:0] own_address;
   logic [7:0] rx_data, tx_data, shreg, tx_shift;
   logic [irq_bits-1:0] irq_status, irq_enable, irq_event;
   logic [3:0] bit_cnt, w_strb;
   logic [4:0] waddr;
   logic [ADDR_WIDTH-1:0] aw_addr;
   logic [31:0] w_data, next_rdata;
   phase_t phase;
   bus_view_t bus;

   // ==========================================================
   // Pin synchronisers and edge detection.
   pin_sync #(.WIDTH(2)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pins({scl_in, sda_in}),
      .level(bus.level),
      .rise(bus.rise),
      .fall(bus.fall)
   );

   // Hold enables and bus activity apply only to an enabled slave port.
   assign slave_active = port_enable & slave_mode;
   assign byte_done = (phase == st_shift) && bus.fall.scl && (bit_cnt == byte_bits);
   assign address_match = shreg[7:1] == own_address;

   // Hardware hold request at the eighth falling edge of a byte.
   always_comb begin
      hold_now = 1'b0;
      irq_event = '0;
      if (byte_done && slave_active) begin
         if (is_address) begin
            if (address_match) begin
               irq_event[irq_address_match] = 1'b1;
               hold_now = address_hold_enable;
            end
         end else if (!read_dir) begin
            irq_event[irq_data_received] = 1'b1;
            hold_now = data_hold_enable;
         end
      end
      irq_event[irq_hold] = hold_now;
      irq_event[irq_stop] = slave_active && (phase != st_idle) && bus.level.scl && bus.rise.sda;
   end

   // ==========================================================
   // Protocol phase, bit counter and shift registers.
   always_ff @(posedge aclk) begin
      if (!aresetn || !slave_active) begin
         phase <= st_idle;
         bit_cnt <= '0;
         shreg <= '0;
         tx_shift <= '0;
         is_address <= 1'b0;
         read_dir <= 1'b0;
      end else if (bus.level.scl && bus.fall.sda) begin
         // Start or repeated start.
         phase <= st_shift;
         bit_cnt <= '0;
         is_address <= 1'b1;
         read_dir <= 1'b0;
      end else if (bus.level.scl && bus.rise.sda) begin
         // Stop.
         phase <= st_idle;
      end else begin
         case (phase)
            st_shift: begin
               if (bus.rise.scl) begin
                  shreg <= {shreg[6:0], bus.level.sda};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (byte_done) begin
                  if (is_address) begin
                     phase <= address_match ? st_ack : st_wait;
                     read_dir <= shreg[0];
                  end else begin
                     phase <= read_dir ? st_master_ack : st_ack;
                  end
               end else if (bus.fall.scl && bit_cnt != 4'h0) begin
                  tx_shift <= {tx_shift[6:0], 1'b1};
               end
            end
            st_ack: begin
               // Acknowledge slot ends at the ninth falling edge.
               if (bus.fall.scl) begin
                  phase <= nack ? st_wait : st_shift;
                  bit_cnt <= '0;
                  is_address <= 1'b0;
                  tx_shift <= read_dir ? tx_data : 8'hFF;
               end
            end
            st_master_ack: begin
               // A released SDA at the ninth rise ends the transfer.
               if (bus.rise.scl && bus.level.sda) begin
                  phase <= st_wait;
               end else if (bus.fall.scl) begin
                  phase <= st_shift;
                  bit_cnt <= '0;
                  tx_shift <= tx_data;
               end
            end
            default: phase <= phase;
         endcase
      end
   end

   // Received byte capture for software.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_data <= '0;
         rx_was_address <= 1'b0;
      end else if (byte_done && slave_active && (is_address ? address_match : !read_dir)) begin
         rx_data <= shreg;
         rx_was_address <= is_address;
      end
   end

   // Acknowledge-time status: 8th fall to the next 9th rise in an acknowledge slot, only with a hold enable.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acknowledge_time_status <= 1'b0;
      end else if (!slave_active || !(address_hold_enable || data_hold_enable)) begin
         acknowledge_time_status <= 1'b0;
      end else if (byte_done) begin
         acknowledge_time_status <= 1'b1;
      end else if (bus.rise.scl && (phase == st_ack || phase == st_master_ack)) begin
         acknowledge_time_status <= 1'b0;
      end
   end

   // ==========================================================
   // Pin drive: SCL is stretched while the port is an enabled slave and the clock release bit is clear.
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = slave_active & ~clock_release_bit;
   assign sda_oe = (phase == st_ack && !nack) || (phase == st_shift && read_dir && !is_address && !tx_shift[7]);

   // ==========================================================
   // AXI4-Lite write channel capture.
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign waddr = aw_addr[4:0];
   assign wr_mapped = (aw_addr[ADDR_WIDTH-1:2] <= 7) && (aw_addr[1:0] == 2'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response one cycle after both halves are held.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= resp_okay;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? resp_okay : resp_slverr;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control registers; the byte lane 0 strobe gates every field.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_enable <= 1'b0;
         slave_mode <= 1'b0;
         nack <= 1'b0;
         address_hold_enable <= 1'b0;
         data_hold_enable <= 1'b0;
         own_address <= own_address_reset;
         tx_data <= tx_data_reset;
         irq_enable <= '0;
      end else if (do_write && wr_mapped && w_strb[0]) begin
         if (waddr == off_control_one) begin
            port_enable <= w_data[bit_port_enable];
            slave_mode <= w_data[bit_slave_mode];
            nack <= w_data[bit_nack];
         end else if (waddr == off_control_three) begin
            address_hold_enable <= w_data[bit_address_hold];
            data_hold_enable <= w_data[bit_data_hold];
         end else if (waddr == off_own_address) begin
            own_address <= w_data[6:0];
         end else if (waddr == off_tx_data) begin
            tx_data <= w_data[7:0];
         end else if (waddr == off_irq_enable) begin
            irq_enable <= w_data[irq_bits-1:0];
         end
      end
   end

   // Clock release bit: a hardware hold clears it, software sets it again.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clock_release_bit <= clock_release_reset;
      end else if (hold_now) begin
         clock_release_bit <= 1'b0;
      end else if (do_write && wr_mapped && w_strb[0] && waddr == off_control_one) begin
         clock_release_bit <= w_data[bit_clock_release];
      end
   end

   // Sticky interrupt status; a new event wins over a clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= '0;
      end else if (do_write && wr_mapped && w_strb[0] && waddr == off_irq_clear) begin
         irq_status <= (irq_status & ~w_data[irq_bits-1:0]) | irq_event;
      end else begin
         irq_status <= irq_status | irq_event;
      end
   end
   assign irq = |(irq_status & irq_enable);

   // ==========================================================
   // AXI4-Lite read channel.
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      next_rdata = '0;
      rd_mapped = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr[ADDR_WIDTH-1:2] <= 7;
      if (s_axi_araddr[4:0] == off_control_one) begin
         next_rdata[bit_port_enable] = port_enable;
         next_rdata[bit_slave_mode] = slave_mode;
         next_rdata[bit_clock_release] = clock_release_bit;
         next_rdata[bit_nack] = nack;
      end else if (s_axi_araddr[4:0] == off_control_three) begin
         next_rdata[bit_ack_time] = acknowledge_time_status;
         next_rdata[bit_address_hold] = address_hold_enable;
         next_rdata[bit_data_hold] = data_hold_enable;
      end else if (s_axi_araddr[4:0] == off_own_address) begin
         next_rdata[6:0] = own_address;
      end else if (s_axi_araddr[4:0] == off_rx_data) begin
         next_rdata[7:0] = rx_data;
         next_rdata[bit_rx_was_address] = rx_was_address;
         next_rdata[bit_rx_read_dir] = read_dir;
      end else if (s_axi_araddr[4:0] == off_tx_data) begin
         next_rdata[7:0] = tx_data;
      end else if (s_axi_araddr[4:0] == off_irq_status) begin
         next_rdata[irq_bits-1:0] = irq_status;
      end else if (s_axi_araddr[4:0] == off_irq_enable) begin
         next_rdata[irq_bits-1:0] = irq_enable;
      end
   end

   // Read data registered one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= resp_okay;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mapped ? next_rdata : 32'h0000_0000;
         s_axi_rresp <= rd_mapped ? resp_okay : resp_slverr;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : i2c_slave_clock_hold

/* File: hold_checker.sv */
`timescale 1ns/1ps

// ==========================================================
// Port-level checker for the clock-hold slave.
module hold_checker (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus handshakes.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Two-wire pins.
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_out,
   input wire logic sda_oe
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Register bus answers and their standing.
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("Write response missing two cycles after both halves.");
   a_resp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped before bready.");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read data missing one cycle after the address.");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data changed before rready.");

   // Clock stretching starts with SCL low and ends only by a register write.
   a_stretch_low: assert property ($rose(scl_oe) |-> !scl_in && !$past(scl_in, 2))
      else $error("Stretch began while SCL was high.");
   a_release_write: assert property ($fell(scl_oe) |-> $rose(s_axi_bvalid))
      else $error("Stretch ended without a completed write.");
   a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("SDA drive changed while SCL was high.");
   a_pull_only: assert property (!scl_out && !sda_out)
      else $error("Open-drain pin driven to a high level.");
endmodule : hold_checker

bind i2c_slave_clock_hold hold_checker i_hold_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .scl_in, .scl_out, .scl_oe, .sda_out, .sda_oe);

/* File: i2c_master_model.sv */
`timescale 1ns/1ps

// ==========================================================
// Behavioural two-wire master that waits out clock stretching.
module i2c_master_model (
   // Clock.
   input wire logic aclk,
   // Resolved bus lines.
   input wire logic scl_line,
   input wire logic sda_line,
   // Pulls, high while the master pulls a line low.
   output logic scl_pull,
   output logic sda_pull
);
   localparam int half = 20;
   int timeouts = 0;

   // Both lines start released.
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end

   task automatic pause(input int n);
      repeat (n) @(posedge aclk);
   endtask : pause

   // Releases SCL and waits, bounded, while the slave holds it low.
   task automatic clock_high();
      int n;
      scl_pull <= 1'b0;
      @(posedge aclk);
      for (n = 0; n < 4000 && !scl_line; n++) @(posedge aclk);
      if (!scl_line) timeouts++;
      pause(half);
   endtask : clock_high

   task automatic start_cond();
      sda_pull <= 1'b1;
      pause(half);
      scl_pull <= 1'b1;
      pause(half);
   endtask : start_cond

   // Eight bits, most significant first, ending with SCL low.
   task automatic send_bits(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sda_pull <= !b[i];
         pause(half);
         clock_high();
         scl_pull <= 1'b1;
         pause(4);
      end
   endtask : send_bits

   task automatic ack_bit(output logic ack);
      sda_pull <= 1'b0;
      pause(half);
      clock_high();
      ack = sda_line;
      scl_pull <= 1'b1;
      pause(half);
   endtask : ack_bit

   task automatic stop_cond();
      sda_pull <= 1'b1;
      pause(half);
      clock_high();
      sda_pull <= 1'b0;
      pause(half);
   endtask : stop_cond
endmodule : i2c_master_model

/* File: tb_top.sv */
`timescale 1ns/1ps

// ==========================================================
// Self-checking bench for the clock-hold slave.
module tb_top import i2c_hold_pkg::*;;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, irq, m_scl, m_sda;
   logic [31:0] ctl1_m, ctl3_m, st_m, en_m;
   int n_errors = 0;
   int comparisons = 0;

   // Open-drain lines with pull-ups.
   assign scl_in = !(scl_oe || m_scl);
   assign sda_in = !(sda_oe || m_sda);

   i2c_slave_clock_hold i_i2c_slave_clock_hold (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe, .irq);
   i2c_master_model i_i2c_master_model (.aclk, .scl_line(scl_in), .sda_line(sda_in), .scl_pull(m_scl),
      .sda_pull(m_sda));

   // Clock of 5 ns period.
   initial begin
      forever #2.5 aclk = !aclk;
   end

   // Watchdog cuts a hang short.
   initial begin
      repeat (100000) @(posedge aclk);
      n_errors++;
      final_report();
   end

   task automatic final_report();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Register write; valids drop at the edge that takes them.
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic ta, tw, tb;
      @(posedge aclk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      for (n = 0; n < 100; n++) begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) s_axi_bready <= 1'b0;
         if (tb) break;
      end
      if (!tb) n_errors++;
      if (!tb) final_report();
   endtask : axi_write

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_write(8'(a), d, r);
   endtask : wr

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ta, rv;
      @(posedge aclk);
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      s_axi_araddr <= a;
      for (n = 0; n < 100; n++) begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         rv = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (rv) s_axi_rready <= 1'b0;
         if (rv) break;
      end
      if (!rv) n_errors++;
      if (!rv) final_report();
   endtask : axi_read

   task automatic rd_check(input string name, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_read(a, d, r);
      check(name, d, e);
   endtask : rd_check

   // One byte from the master, with model expectations at the hold point.
   task automatic byte_step(input logic [7:0] b, input logic is_addr);
      logic ok, hold, ack;
      logic [31:0] c3e;
      ok = ctl1_m[0] && ctl1_m[1];
      hold = ok && (is_addr ? ctl3_m[1] : ctl3_m[0]);
      i_i2c_master_model.send_bits(b);
      repeat (10) @(posedge aclk);
      if (ok) st_m |= is_addr ? 32'h1 : 32'h2;
      if (hold) st_m |= 32'h8;
      if (hold) ctl1_m &= ~32'h10;
      c3e = ctl3_m | ((ok && ctl3_m[1:0] != 2'h0) ? 32'h80 : 32'h0);
      check("scl_oe", 32'(scl_oe), 32'(hold));
      rd_check("control_one", 8'(off_control_one), ctl1_m);
      rd_check("ack_time_set", 8'(off_control_three), c3e);
      rd_check("irq_status", 8'(off_irq_status), st_m);
      check("irq", 32'(irq), 32'(|(st_m & en_m)));
      if (ok && !is_addr) rd_check("rx_data", 8'(off_rx_data), 32'(b));
      if (hold) begin
         fork
            i_i2c_master_model.ack_bit(ack);
            begin
               repeat (40) @(posedge aclk);
               check("scl_held", 32'(scl_in), 32'h0);
               wr(off_control_one, ctl1_m | 32'h10);
            end
         join
         ctl1_m |= 32'h10;
      end else begin
         i_i2c_master_model.ack_bit(ack);
      end
      check("ack", 32'(ack), 32'(!ok));
      rd_check("ack_time_clear", 8'(off_control_three), ctl3_m);
   endtask : byte_step

   // Frame: configure, clear status, address byte, then random data bytes.
   task automatic frame(input logic [31:0] c1, input logic [31:0] c3, input int nbytes);
      ctl1_m = c1;
      ctl3_m = c3;
      en_m = 32'h8;
      st_m = 32'h0;
      wr(off_control_one, c1);
      wr(off_control_three, c3);
      wr(off_irq_enable, en_m);
      wr(off_irq_clear, 32'hF);
      check("irq_cleared", 32'(irq), 32'h0);
      i_i2c_master_model.start_cond();
      byte_step({own_address_reset, 1'b0}, 1'b1);
      repeat (nbytes) byte_step(8'($urandom), 1'b0);
      i_i2c_master_model.stop_cond();
      $display("Test frame %h %h done", c1, c3);
   endtask : frame

   // Main sequence.
   initial begin
      logic [7:0] offs [7];
      logic [31:0] vals [7];
      logic [31:0] d;
      logic [1:0] r;
      offs = '{8'(off_control_one), 8'(off_control_three), 8'(off_own_address), 8'(off_tx_data),
         8'(off_irq_status), 8'(off_irq_clear), 8'(off_irq_enable)};
      vals = '{32'h10, 32'h0, 32'h2A, 32'hFF, 32'h0, 32'h0, 32'h0};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h0;
      s_axi_wdata = 32'h0;
      void'($urandom(32'h0FA5));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 7; i++) rd_check("reset_value", offs[i], vals[i]);
      axi_write(8'h20, 32'hFFFF_FFFF, r);
      check("unmapped_bresp", 32'(r), 32'(resp_slverr));
      axi_read(8'h20, d, r);
      check("unmapped_rresp", 32'(r), 32'(resp_slverr));
      check("unmapped_rdata", d, 32'h0);
      $display("Test registers done");
      frame(32'h13, 32'h02, 1);
      frame(32'h13, 32'h01, 2);
      frame(32'h13, 32'h03, 1);
      frame(32'h11, 32'h03, 1);
      frame(32'h12, 32'h03, 1);
      check("master_timeouts", 32'(i_i2c_master_model.timeouts), 32'h0);
      final_report();
   end
endmodule : tb_top
